// ==== hw/pom_out_ctrl.sv ====
// output path control: path selector, mute arbitration, stage config registers, fault recovery
// assumes pwm inputs, fault input and register port are synchronous to clk;
// rst_n is the power down pin
//
// Notes on behaviour
// RQ1 - selector low enables headphone and disables speakers; high does the opposite. Only speaker outputs 1 and 2 are blanked here; 3 to 8 keep driving.
// RQ2 - headphone carries processed channels 1 and 2.
// RQ3 - in six channel mode the selector leaves lineouts 5 and 6 alone.
// RQ4 - selector change soft mutes to quiet, switches path, then soft unmutes.
// RQ5 - headphone active: channels 1 and 2 use headphone config, else own.
// RQ6 - remapped mixer in six channel mode: controller pulses mute pin after changes; this block does not, mute_pin_n is only an input here.
// RQ7 - master mute bit and mute pin, both active low, combine to mute all.
// RQ8 - mute ramps gain down smoothly; release ramps back smoothly.
// RQ9 - master mute plus per channel mutes that touch only their channel.
// RQ10 - a muted channel stops switching and settles to idle levels.
// RQ11 - any mute source overrides unmute and volume commands.
// RQ12 - unmute returns to latest volume, including commands taken while muted.
// RQ13 - eight channel config registers at channel1_stage_config to channel8_stage_config; host programs them.
// RQ14 - bit 7 picks error recovery on fault or uninterrupted running.
// RQ15 - bit 6 pulls stage ok low when the stage needs a reset.
// RQ16 - bit 5 pulls stage ok low when the stage must be muted.
// RQ17 - host should clear bits 6 and 5 for stages controlled through pwm.
// RQ18 - bit 4 inverts the channel's pwm polarity.
// RQ19 - host sets bit 3 only for one particular stage type.
// RQ20 - bit 1 drives both pwm outputs high during mute.
// RQ21 - bit 0 unused; bit 2 is an optional pop control.
// RQ22 - headphone config means the same; only its default value is used.
// RQ23 - fault is input low five cycles; wait 5 ms before re-initialising.
// RQ24 - six channel mode makes channels 5 and 6 lineouts.
// RQ25 - selector and mute pin pass a two stage synchroniser first.
// RQ26 - selector change during a path sequence waits until it completes.
`timescale 1ns/1ps
module pom_out_ctrl
  import pom_pkg::*;
#(
  parameter int FAULT_WAIT = FAULT_WAIT_CYC
)
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        output_path_select,
  input  wire logic                        mute_pin_n,
  input  wire logic                        master_mute_n,
  input  wire logic                        six_ch_mode,
  input  wire logic [pom_pkg::NUM_CH-1:0]  chan_mute,
  input  wire logic [pom_pkg::NUM_CH-1:0]  auto_mute,
  input  wire logic                        am_mute,
  input  wire logic                        bank_mute,
  input  wire logic [pom_pkg::NUM_CH-1:0][7:0] chan_vol,
  input  wire logic [pom_pkg::NUM_CH-1:0]  pwm_p_in,
  input  wire logic [pom_pkg::NUM_CH-1:0]  pwm_m_in,
  input  wire logic                        stage_fault_in,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  output logic      [pom_pkg::NUM_CH-1:0]  spk_p,
  output logic      [pom_pkg::NUM_CH-1:0]  spk_m,
  output logic      [1:0]                  hp_p,
  output logic      [1:0]                  hp_m,
  output logic      [pom_pkg::NUM_CH-1:0][7:0] chan_gain,
  output logic                             stage_ok,
  output logic                             hp_active,
  output logic                             path_busy
);

  import pom_pkg::*;

  logic [7:0]        cfg_q [NUM_CH];
  logic [7:0]        idx;
  logic              in_range;
  logic [1:0]        sel_sync;
  logic [1:0]        mute_sync;
  logic              hp_want;
  logic              path_mute;
  logic [NUM_CH-1:0] path_mask;
  logic [NUM_CH-1:0] affected;
  logic [NUM_CH-1:0] st_p;
  logic [NUM_CH-1:0] st_m;
  logic [NUM_CH-1:0] st_idle;
  logic [NUM_CH-1:0] st_settled;
  logic [NUM_CH-1:0] rst_bits;
  logic [NUM_CH-1:0] mute_bits;
  logic [NUM_CH-1:0] ch_mute;
  logic              fault_active;
  logic [2:0]        low_cnt;
  logic [19:0]       wait_cnt;
  logic [7:0]        tick_cnt;
  logic              tick;
  logic              unmute_seen;
  pom_path_t         path_st;
  pom_fault_t        fault_st;

  // -------------------------------------------------------------
  // register port
  // -------------------------------------------------------------
  assign idx      = reg_addr - CFG_FIRST_OFS;
  assign in_range = (reg_addr >= CFG_FIRST_OFS) && (reg_addr <= CFG_LAST_OFS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else if (reg_wr && in_range) begin
      cfg_q[idx[2:0]] <= reg_wdata; // RQ13
    end
  end

  // headphone config is fixed at its default, so writes to it are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (in_range) begin
      reg_rdata <= cfg_q[idx[2:0]]; // RQ13
    end else if (reg_addr == HP_CFG_OFS) begin
      reg_rdata <= HP_CFG_DEFAULT; // RQ22
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync  <= 2'h3;
      mute_sync <= 2'h3;
    end else begin
      sel_sync  <= {sel_sync[0], output_path_select}; // RQ25
      mute_sync <= {mute_sync[0], mute_pin_n}; // RQ25
    end
  end

  assign hp_want = !sel_sync[1]; // RQ1

  // -------------------------------------------------------------
  // ramp tick
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 8'h00;
    end else if (tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  assign tick = (tick_cnt == RAMP_TICK_CYC - 8'h01);

  // -------------------------------------------------------------
  // path switch sequence
  // -------------------------------------------------------------
  // lineouts are kept out of both the path mute and the completion checks
  assign path_mask = six_ch_mode ? ~LINEOUT_MASK : {NUM_CH{1'b1}}; // RQ3 RQ24
  assign path_mute = (path_st == PS_MUTE) || (path_st == PS_SWITCH);
  assign path_busy = (path_st != PS_IDLE);

  // a new selector level is only compared in idle, so it waits out a running sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      path_st   <= PS_IDLE;
      hp_active <= 1'b0;
    end else begin
      case (path_st)
        PS_IDLE: begin
          if (hp_want != hp_active) begin
            path_st <= PS_MUTE; // RQ4 RQ26
          end
        end
        PS_MUTE: begin
          if ((st_idle & path_mask) == path_mask) begin
            path_st <= PS_SWITCH; // RQ4
          end
        end
        PS_SWITCH: begin
          hp_active <= !hp_active; // RQ4
          path_st   <= PS_UNMUTE;
        end
        PS_UNMUTE: begin
          if (unmute_seen && ((st_settled & path_mask) == path_mask)) begin
            path_st <= PS_IDLE; // RQ26
          end
        end
        default: begin
          path_st <= PS_IDLE;
        end
      endcase
    end
  end

  // settled flags lag a cycle, so the first unmute cycle still shows the muted state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unmute_seen <= 1'b0;
    end else begin
      unmute_seen <= (path_st == PS_UNMUTE); // RQ26
    end
  end

  // -------------------------------------------------------------
  // stage fault recovery
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_st <= FS_RUN;
      low_cnt  <= 3'h0;
      wait_cnt <= 20'h00000;
    end else begin
      case (fault_st)
        FS_RUN: begin
          wait_cnt <= 20'h00000;
          if (stage_fault_in) begin
            low_cnt <= 3'h0;
          end else if (low_cnt == 3'(FAULT_MIN_CYC - 1)) begin
            low_cnt  <= 3'h0;
            fault_st <= FS_WAIT; // RQ23
          end else begin
            low_cnt <= low_cnt + 3'h1;
          end
        end
        FS_WAIT: begin
          if (wait_cnt == 20'(FAULT_WAIT - 1)) begin
            fault_st <= FS_RUN; // RQ23
          end else begin
            wait_cnt <= wait_cnt + 20'h00001;
          end
        end
        default: begin
          fault_st <= FS_RUN;
        end
      endcase
    end
  end

  assign fault_active = (fault_st == FS_WAIT);

  // -------------------------------------------------------------
  // channel stages
  // -------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    pom_stage_if sif ();
    logic [7:0] cfg_use;

    assign cfg_use = (i < 2 && hp_active) ? HP_CFG_DEFAULT : cfg_q[i]; // RQ5 RQ22
    // lineouts in six channel mode ride through a stage fault
    assign affected[i] = cfg_use[B_RECOVER] && !(six_ch_mode && LINEOUT_MASK[i]); // RQ14
    assign ch_mute[i] = !master_mute_n || !mute_sync[1] // RQ7
                      || chan_mute[i] || auto_mute[i] || am_mute || bank_mute // RQ9 RQ11
                      || (path_mute && path_mask[i]); // RQ4

    assign sif.cfg      = cfg_use;
    assign sif.vol      = chan_vol[i];
    assign sif.mute     = ch_mute[i];
    assign sif.halt     = fault_active && affected[i]; // RQ14
    assign sif.tick     = tick;
    assign sif.pwm_p_in = pwm_p_in[i];
    assign sif.pwm_m_in = pwm_m_in[i];
    assign chan_gain[i] = sif.gain;
    assign st_p[i]       = sif.p;
    assign st_m[i]       = sif.m;
    assign st_idle[i]    = sif.idle;
    assign st_settled[i] = sif.settled;
    assign rst_bits[i]   = sif.halt && cfg_use[B_RST_VALID];
    assign mute_bits[i]  = sif.idle && cfg_use[B_MUTE_VALID];

    pom_stage u_stage (
      .clk   (clk),
      .rst_n (rst_n),
      .s     (sif.stage)
    );
  end

  // -------------------------------------------------------------
  // output routing
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_ok <= 1'b0;
    end else begin
      stage_ok <= !(|rst_bits) && !(|mute_bits); // RQ15 RQ16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spk_p <= '0;
      spk_m <= '0;
      hp_p  <= 2'h0;
      hp_m  <= 2'h0;
    end else if (hp_active) begin
      spk_p <= {st_p[NUM_CH-1:2], 2'h0}; // RQ1
      spk_m <= {st_m[NUM_CH-1:2], 2'h0};
      hp_p  <= st_p[1:0]; // RQ2
      hp_m  <= st_m[1:0]; // RQ2
    end else begin
      spk_p <= st_p; // RQ1
      spk_m <= st_m;
      hp_p  <= 2'h0;
      hp_m  <= 2'h0;
    end
  end

endmodule : pom_out_ctrl

// ==== shared/pom_pkg.sv ====
// constants, field positions and state types for the output mute and stage config block
// assumes one processing clock; the register port is the subaddress side of the control interface
package pom_pkg;

  localparam int NUM_CH = 8;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] CFG_FIRST_OFS  = 8'h05;
  localparam logic [7:0] CFG_LAST_OFS   = 8'h0c;
  localparam logic [7:0] HP_CFG_OFS     = 8'h0d;
  localparam logic [7:0] CFG_RESET      = 8'he0;
  localparam logic [7:0] HP_CFG_DEFAULT = 8'he0;

  // -------------------------------------------------------------
  // stage config fields
  // -------------------------------------------------------------
  localparam int B_RECOVER    = 7;
  localparam int B_RST_VALID  = 6;
  localparam int B_MUTE_VALID = 5;
  localparam int B_INVERT     = 4;
  localparam int B_STAGE_TYPE = 3;
  localparam int B_POP        = 2;
  localparam int B_HIGH_IDLE  = 1;
  localparam int B_UNUSED     = 0;

  // channels 5 and 6 act as lineouts in six channel mode
  localparam logic [NUM_CH-1:0] LINEOUT_MASK = 8'h30;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int FAULT_MIN_CYC  = 5;
  localparam int FAULT_WAIT_MS  = 5;
  localparam int FAULT_WAIT_CYC = FAULT_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_TICK_CYC = 8'h10;

  typedef enum {PS_IDLE, PS_MUTE, PS_SWITCH, PS_UNMUTE} pom_path_t;
  typedef enum {FS_RUN, FS_WAIT} pom_fault_t;

endpackage : pom_pkg

// ==== shared/pom_stage_if.sv ====
// signals between the controller and one channel output stage
// assumes both ends share clk
`timescale 1ns/1ps
interface pom_stage_if;
  logic [7:0] cfg;
  logic [7:0] vol;
  logic [7:0] gain;
  logic       mute;
  logic       halt;
  logic       tick;
  logic       pwm_p_in;
  logic       pwm_m_in;
  logic       p;
  logic       m;
  logic       idle;
  logic       settled;

  modport stage (input cfg, vol, mute, halt, tick, pwm_p_in, pwm_m_in,
                 output gain, p, m, idle, settled);
  modport ctrl  (output cfg, vol, mute, halt, tick, pwm_p_in, pwm_m_in,
                 input gain, p, m, idle, settled);
endinterface : pom_stage_if

// ==== hw/pom_stage.sv ====
// one channel: soft gain ramp, mute idle levels, fault halt, polarity
// assumes the controller resolves all mute sources into s.mute
`timescale 1ns/1ps
module pom_stage
  import pom_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  pom_stage_if.stage  s
);

  logic [7:0] target;

  // -------------------------------------------------------------
  // gain ramp
  // -------------------------------------------------------------
  // target follows the live volume, so an unmute lands on the latest command
  assign target = s.mute ? 8'h00 : s.vol; // RQ11 RQ12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.gain <= 8'h00;
    end else if (s.tick) begin
      if (s.gain < target) begin
        s.gain <= s.gain + 8'h01; // RQ8
      end else if (s.gain > target) begin
        s.gain <= s.gain - 8'h01; // RQ8
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.idle    <= 1'b1;
      s.settled <= 1'b0;
    end else begin
      s.idle    <= s.mute && (s.gain == 8'h00); // RQ10
      s.settled <= (s.gain == target);
    end
  end

  // -------------------------------------------------------------
  // pwm outputs
  // -------------------------------------------------------------
  // bit 0 and the pop and stage type bits have no effect on this path
  always_ff @(posedge clk or negedge rst_n) begin // RQ21
    if (!rst_n) begin
      s.p <= 1'b0;
      s.m <= 1'b0;
    end else if (s.halt) begin
      s.p <= 1'b0; // RQ14
      s.m <= 1'b0;
    end else if (s.idle) begin
      s.p <= s.cfg[B_HIGH_IDLE]; // RQ10 RQ20
      s.m <= s.cfg[B_HIGH_IDLE]; // RQ20
    end else begin
      s.p <= s.pwm_p_in ^ s.cfg[B_INVERT]; // RQ18
      s.m <= s.pwm_m_in ^ s.cfg[B_INVERT]; // RQ18
    end
  end

endmodule : pom_stage

// ==== bench/pom_out_ctrl_properties.sv ====
// port level assertions for the output path and mute controller
// assumes it is bound onto pom_out_ctrl and sees one clock domain
`timescale 1ns/1ps
module pom_out_ctrl_properties
  import pom_pkg::*;
(
  input wire logic                             clk,
  input wire logic                             rst_n,
  input wire logic                             master_mute_n,
  input wire logic                             reg_wr,
  input wire logic [7:0]                       reg_addr,
  input wire logic [7:0]                       reg_wdata,
  input wire logic [7:0]                       reg_rdata,
  input wire logic [pom_pkg::NUM_CH-1:0]       spk_p,
  input wire logic [pom_pkg::NUM_CH-1:0]       spk_m,
  input wire logic [1:0]                       hp_p,
  input wire logic [1:0]                       hp_m,
  input wire logic [pom_pkg::NUM_CH-1:0][7:0]  chan_gain,
  input wire logic                             hp_active,
  input wire logic                             path_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // sequences
  // ----
  sequence s_cfg_write;
    reg_wr && reg_addr inside {[CFG_FIRST_OFS:CFG_LAST_OFS]} ##1 $stable(reg_addr) ##1 $stable(reg_addr);
  endsequence
  sequence s_mute_held;
    !master_mute_n [*3];
  endsequence
  sequence s_gain_moved;
    $changed(chan_gain[2]);
  endsequence
  // ----
  // assertions
  // ----
  a_hp_blocks_spk: assert property (hp_active && $past(hp_active) && $past(hp_active, 2) |->
    spk_p[1:0] == 2'h0 && spk_m[1:0] == 2'h0) else $error("speaker pair active on headphone path");
  a_hp_idle_quiet: assert property (!hp_active && !$past(hp_active) && !$past(hp_active, 2) |->
    hp_p == 2'h0 && hp_m == 2'h0) else $error("headphone active on speaker path");
  a_switch_in_seq: assert property ($changed(hp_active) |-> path_busy)
    else $error("path flipped outside a switch sequence");
  a_switch_when_quiet: assert property ($changed(hp_active) |-> chan_gain[0] == 8'h00 && chan_gain[1] == 8'h00)
    else $error("path flipped before gain reached zero");
  a_mute_no_rise: assert property (s_mute_held |-> chan_gain[2] <= $past(chan_gain[2]))
    else $error("gain rose under master mute");
  a_ramp_one_step: assert property (s_gain_moved |-> 8'(chan_gain[2] - $past(chan_gain[2])) inside {8'h01, 8'hff})
    else $error("gain jumped by more than one step");
  a_ramp_spacing: assert property (s_gain_moved |=> $stable(chan_gain[2]) [*8])
    else $error("gain steps too close together");
  a_cfg_write_seen: assert property (s_cfg_write |-> reg_rdata == $past(reg_wdata, 2))
    else $error("written config not read back");
  a_unmapped_zero: assert property (!($past(reg_addr) inside {[CFG_FIRST_OFS:HP_CFG_OFS]}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_hp_cfg_fixed: assert property ($past(reg_addr) == HP_CFG_OFS |-> reg_rdata == HP_CFG_DEFAULT)
    else $error("headphone config not at default");
endmodule : pom_out_ctrl_properties

bind pom_out_ctrl pom_out_ctrl_properties u_props (.clk, .rst_n, .master_mute_n, .reg_wr, .reg_addr, .reg_wdata,
  .reg_rdata, .spk_p, .spk_m, .hp_p, .hp_m, .chan_gain, .hp_active, .path_busy);

// ==== bench/pom_stage_model.sv ====
// stand-in for the external power stages: owns the shared fault line
// assumes the bench asks for fault pulses; the line idles high by its pull-up
`timescale 1ns/1ps
module pom_stage_model (
  input  wire logic clk,
  input  wire logic stage_ok,
  output logic      stage_fault_in
);
  int restarts = 0;
  initial stage_fault_in = 1'b1;
  // low for n whole cycles; fewer than five must be ignored by the device
  task automatic drop_fault(input int n);
    @(negedge clk);
    stage_fault_in = 1'b0;
    repeat (n) @(negedge clk);
    stage_fault_in = 1'b1;
  endtask : drop_fault
  // a stage held by stage_ok restarts when it is released
  always @(posedge stage_ok) restarts++;
endmodule : pom_stage_model

// ==== bench/pom_out_ctrl_test.sv ====
// self-checking bench for pom_out_ctrl through its register port and levels
// assumes a short fault wait parameter and the stage model on the fault line
`timescale 1ns/1ps
module pom_out_ctrl_test;
  import pom_pkg::*;
  logic clk, rst_n, output_path_select, mute_pin_n, master_mute_n, six_ch_mode, am_mute, bank_mute;
  logic stage_fault_in, reg_wr, stage_ok, hp_active, path_busy;
  logic [NUM_CH-1:0] chan_mute, auto_mute, pwm_p_in, pwm_m_in, spk_p, spk_m, inv, aff;
  logic [NUM_CH-1:0][7:0] chan_vol, chan_gain;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] hp_p, hp_m;
  // ch3 clears both stage_ok uses since it is driven through pwm
  logic [7:0] cfg [8] = '{8'h10, 8'he0, 8'h02, 8'he0, 8'h00, 8'h00, 8'hf0, 8'he8};
  int n_mismatch = 0;
  int n_compared = 0;
  int i, k;

  pom_out_ctrl #(.FAULT_WAIT(20)) dut (.clk, .rst_n, .output_path_select, .mute_pin_n, .master_mute_n,
    .six_ch_mode, .chan_mute, .auto_mute, .am_mute, .bank_mute, .chan_vol, .pwm_p_in, .pwm_m_in,
    .stage_fault_in, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .spk_p, .spk_m, .hp_p, .hp_m,
    .chan_gain, .stage_ok, .hp_active, .path_busy);
  pom_stage_model u_stage (.clk, .stage_ok, .stage_fault_in);

  // ----
  // access and compare tasks
  // ----
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask : rd_check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // bounded wait, so a stuck sequence shows as a mismatch
  task automatic wait_busy(input logic v);
    for (int j = 0; j < 2000 && path_busy !== v; j++) @(negedge clk);
    check({7'h0, path_busy}, {7'h0, v});
  endtask : wait_busy
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(20000 * 8);
    n_mismatch++;
    report_and_stop();
  end

  // ----
  // test sequence
  // ----
  initial begin
    {rst_n, six_ch_mode, am_mute, bank_mute, reg_wr, chan_mute, auto_mute, pwm_m_in} = '0;
    {output_path_select, mute_pin_n, master_mute_n} = 3'h7;
    {reg_addr, reg_wdata, pwm_p_in} = {16'h0, 8'hff};
    chan_vol = {8{8'h04}};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) rd_check(CFG_FIRST_OFS + 8'(i), CFG_RESET);
    wr(HP_CFG_OFS, 8'h00);
    rd_check(HP_CFG_OFS, HP_CFG_DEFAULT);
    wr(8'h04, 8'h5a);
    rd_check(8'h04, 8'h00);
    rd_check(8'h0e, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(CFG_FIRST_OFS + 8'(i), cfg[i]);
      rd_check(CFG_FIRST_OFS + 8'(i), cfg[i]);
      inv[i] = cfg[i][B_INVERT];
      aff[i] = cfg[i][B_RECOVER] & ~LINEOUT_MASK[i];
    end
    cyc(120);
    for (i = 0; i < 8; i++) check(chan_gain[i], 8'h04);
    check(spk_p, 8'hff ^ inv);
    check(spk_m, inv);
    chan_mute = 8'h0c;
    cyc(120);
    check(chan_gain[2], 8'h00);
    check(chan_gain[1], 8'h04);
    check({4'h0, spk_p[3:2], spk_m[3:2]}, 8'h05);
    check({7'h0, stage_ok}, 8'h00);
    chan_vol[2] = 8'h06;
    cyc(40);
    check(chan_gain[2], 8'h00);
    chan_mute = 8'h00;
    cyc(150);
    check(chan_gain[2], 8'h06);
    check({7'h0, stage_ok}, 8'h01);
    for (k = 0; k < 5; k++) begin
      master_mute_n = (k != 0);
      mute_pin_n = (k != 1);
      am_mute = (k == 2);
      bank_mute = (k == 3);
      auto_mute = {8{k == 4}};
      cyc(150);
      for (i = 0; i < 8; i++) check(chan_gain[i], 8'h00);
      {master_mute_n, mute_pin_n, am_mute, bank_mute, auto_mute} = {2'h3, 10'h0};
      cyc(150);
      check(chan_gain[2], 8'h06);
    end
    six_ch_mode = 1'b1;
    output_path_select = 1'b0;
    wait_busy(1'b1);
    for (i = 0; i < 500 && chan_gain[0] !== 8'h00; i++) @(negedge clk);
    check(chan_gain[4], 8'h04);
    wait_busy(1'b0);
    check({7'h0, hp_active}, 8'h01);
    check({4'h0, hp_p, hp_m}, 8'h0c);
    check({6'h0, spk_p[1:0]}, 8'h00);
    output_path_select = 1'b1;
    wait_busy(1'b1);
    output_path_select = 1'b0;
    wait_busy(1'b0);
    cyc(4);
    check({7'h0, path_busy}, 8'h01);
    wait_busy(1'b0);
    check({7'h0, hp_active}, 8'h01);
    // host pulses the mute pin after a selector change in six channel mode
    mute_pin_n = 1'b0;
    cyc(150);
    check(chan_gain[4], 8'h00);
    mute_pin_n = 1'b1;
    cyc(150);
    check(chan_gain[4], 8'h04);
    u_stage.drop_fault(4);
    cyc(4);
    check(spk_p, (8'hff ^ inv) & 8'hfc);
    k = u_stage.restarts;
    u_stage.drop_fault(5);
    cyc(4);
    check(spk_p, (8'hff ^ inv) & 8'hfc & ~aff);
    check({7'h0, stage_ok}, 8'h00);
    cyc(30);
    check(spk_p, (8'hff ^ inv) & 8'hfc);
    check({7'h0, stage_ok}, 8'h01);
    check(8'(u_stage.restarts - k), 8'h01);
    report_and_stop();
  end
endmodule : pom_out_ctrl_test
